// ---- hw/rrc_pkg.sv ----
// Package: register map, field layout, encodings and carriers of the rail control bank
package rrc_pkg;

    // ------------------------------------------------------------
    // Register map (register indices, word addressed)
    // ------------------------------------------------------------
    localparam logic [15:0] RRC_ADDR_CONTROL   = 16'h4080;
    localparam logic [15:0] RRC_ADDR_ON_CTRL   = 16'h4081;
    localparam logic [15:0] RRC_ADDR_SLEEP     = 16'h4082;
    localparam logic [15:0] RRC_ADDR_IRQ_STAT  = 16'h4088;
    localparam logic [15:0] RRC_ADDR_IRQ_MASK  = 16'h4089;
    localparam logic [15:0] RRC_ADDR_RAIL_STAT = 16'h408A;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RRC_RST_CONTROL  = 16'h0200;
    localparam logic [15:0] RRC_RST_ON_CTRL  = 16'h0000;
    localparam logic [15:0] RRC_RST_SLEEP    = 16'h0100;
    localparam logic [15:0] RRC_RST_IRQ_MASK = 16'h0001;

    // ------------------------------------------------------------
    // Writable bit masks (other bits read as zero)
    // ------------------------------------------------------------
    localparam logic [15:0] RRC_WMASK_CONTROL = 16'hDFC0;
    localparam logic [15:0] RRC_WMASK_SLOTREG = 16'hE11F;
    localparam logic [15:0] RRC_WMASK_IRQ     = 16'h0001;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RRC_ERR_ACT_LSB  = 14;
    localparam int RRC_HWC_SRC_LSB  = 11;
    localparam int RRC_HWC_VSEL_BIT = 10;
    localparam int RRC_HWC_MODE_LSB = 8;
    localparam int RRC_FLT_BIT      = 7;
    localparam int RRC_SWI_BIT      = 6;
    localparam int RRC_SLOT_LSB     = 13;
    localparam int RRC_MODE_BIT     = 8;
    localparam int RRC_VSEL_LSB     = 0;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    localparam logic [1:0] RRC_ACT_IGNORE   = 2'h0;
    localparam logic [1:0] RRC_ACT_RAIL_OFF = 2'h1;
    localparam logic [1:0] RRC_ACT_SYS_OFF  = 2'h2;
    localparam logic [1:0] RRC_SRC_HWC1     = 2'h1;
    localparam logic [1:0] RRC_SRC_HWC2     = 2'h2;
    localparam logic [1:0] RRC_SRC_EITHER   = 2'h3;
    localparam logic [1:0] RRC_HMODE_OFF    = 2'h1;
    localparam logic [1:0] RRC_HMODE_ONMODE = 2'h3;
    localparam logic [2:0] RRC_SLOT_NEVER   = 3'h0;
    localparam logic [2:0] RRC_SLOT_LAST    = 3'h5;
    localparam logic [2:0] RRC_SLOT_HWEN1   = 3'h6;
    localparam logic [2:0] RRC_SLOT_HWEN2   = 3'h7;
    localparam logic [2:0] RRC_SLP_TS5      = 3'h5;
    localparam logic [2:0] RRC_SLP_TS3      = 3'h3;
    localparam logic [2:0] RRC_SLP_TS1      = 3'h1;
    localparam logic [2:0] RRC_SLP_SUM      = 3'h6;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } rrc_bus_s;

    typedef struct packed {
        logic       enable;
        logic       lowPower;
        logic [4:0] voltCode;
        logic       floatOff;
        logic       switchMode;
    } rrc_rail_s;

    typedef enum logic [1:0] {
        RRC_OFF,
        RRC_ON,
        RRC_SLEEP,
        RRC_FAULT
    } rrc_state_e;

endpackage

// ---- hw/rrc_rail_regs.sv ----
// Register bank and control logic for one linear regulator rail
//
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps

module rrc_rail_regs
    import rrc_pkg::*;
#(
    parameter int SLOT_COUNT = 5
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [15:0] regRdata,
    input  wire logic        startupSlotPulse,
    input  wire logic [2:0]  startupSlot,
    input  wire logic        sleepSlotPulse,
    input  wire logic [2:0]  sleepSlot,
    input  wire logic        wakeRequest,
    input  wire logic        hwControl1Pin,
    input  wire logic        hwControl2Pin,
    input  wire logic        hwEnable1Pin,
    input  wire logic        hwEnable2Pin,
    input  wire logic        underVoltPin,
    output logic             railEnable,
    output logic             railLowPower,
    output logic      [4:0]  railVoltCode,
    output logic             railFloatOff,
    output logic             railSwitchMode,
    output logic             railDischarge,
    output logic             systemResetReq,
    output logic             irq
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (SLOT_COUNT != 5) begin : gBadSlots
        $error("SLOT_COUNT must be 5");
    end

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pinRaw;
    logic [4:0] pinMeta;
    logic [4:0] pinSync;
    assign pinRaw = {underVoltPin, hwEnable2Pin, hwEnable1Pin, hwControl2Pin, hwControl1Pin};

    for (genvar i = 0; i < 5; i++) begin : gSync
        always_ff @(posedge ref_clk or negedge rst_n) begin
            if (!rst_n) begin
                pinMeta[i] <= 1'b0;
                pinSync[i] <= 1'b0;
            end else begin
                pinMeta[i] <= pinRaw[i];
                pinSync[i] <= pinMeta[i];
            end
        end
    end

    wire logic hwc1 = pinSync[0];
    wire logic hwc2 = pinSync[1];
    wire logic hwe1 = pinSync[2];
    wire logic hwe2 = pinSync[3];
    wire logic uvLevel = pinSync[4];

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] controlReg;
    logic [15:0] onReg;
    logic [15:0] sleepReg;
    logic        irqStatus;
    logic        irqMask;
    logic        uvLast;
    rrc_state_e  state;
    rrc_state_e  next_state;

    rrc_bus_s bus;
    assign bus = '{addr: regAddr, wdata: regWdata, wr: regWr, rd: regRd};

    wire logic wrControl = bus.wr && (bus.addr == RRC_ADDR_CONTROL);
    wire logic wrOn      = bus.wr && (bus.addr == RRC_ADDR_ON_CTRL);
    wire logic wrSleep   = bus.wr && (bus.addr == RRC_ADDR_SLEEP);
    wire logic wrStat    = bus.wr && (bus.addr == RRC_ADDR_IRQ_STAT);
    wire logic wrMask    = bus.wr && (bus.addr == RRC_ADDR_IRQ_MASK);

    // Field views
    wire logic [1:0] undervoltage_action     = controlReg[RRC_ERR_ACT_LSB +: 2];
    wire logic [1:0] hw_control_source       = controlReg[RRC_HWC_SRC_LSB +: 2];
    wire logic       hw_control_voltage_pick = controlReg[RRC_HWC_VSEL_BIT];
    wire logic [1:0] hw_control_rail_mode    = controlReg[RRC_HWC_MODE_LSB +: 2];
    wire logic       output_float_when_off   = controlReg[RRC_FLT_BIT];
    wire logic       pass_switch_mode        = controlReg[RRC_SWI_BIT];
    wire logic [2:0] on_timeslot_select      = onReg[RRC_SLOT_LSB +: 3];
    wire logic       on_power_mode           = onReg[RRC_MODE_BIT];
    wire logic [4:0] on_voltage_code         = onReg[RRC_VSEL_LSB +: 5];
    wire logic [2:0] sleep_timeslot_select   = sleepReg[RRC_SLOT_LSB +: 3];
    wire logic       sleep_power_mode        = sleepReg[RRC_MODE_BIT];
    wire logic [4:0] sleep_voltage_code      = sleepReg[RRC_VSEL_LSB +: 5];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            controlReg <= RRC_RST_CONTROL;
            onReg      <= RRC_RST_ON_CTRL;
            sleepReg   <= RRC_RST_SLEEP;
            irqMask    <= RRC_RST_IRQ_MASK[0];
        end else begin
            if (wrControl) controlReg <= bus.wdata & RRC_WMASK_CONTROL;
            if (wrOn)      onReg      <= bus.wdata & RRC_WMASK_SLOTREG;
            if (wrSleep)   sleepReg   <= bus.wdata & RRC_WMASK_SLOTREG;
            if (wrMask)    irqMask    <= bus.wdata[0];
        end
    end

    // ------------------------------------------------------------
    // Undervoltage event and interrupt
    // ------------------------------------------------------------
    wire logic uvEvent = uvLevel && !uvLast;
    wire logic statClr = wrStat && bus.wdata[0];
    wire logic next_irqStatus = uvEvent | (irqStatus & ~statClr);

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            uvLast    <= 1'b0;
            irqStatus <= 1'b0;
            irq       <= 1'b0;
        end else begin
            uvLast    <= uvLevel;
            irqStatus <= next_irqStatus;
            irq       <= next_irqStatus & irqMask;
        end
    end

    // ------------------------------------------------------------
    // Hardware control and hardware enable
    // ------------------------------------------------------------
    wire logic hwcActive =
        ((hw_control_source == RRC_SRC_HWC1) && hwc1) ||
        ((hw_control_source == RRC_SRC_HWC2) && hwc2) ||
        ((hw_control_source == RRC_SRC_EITHER) && (hwc1 || hwc2));

    wire logic onByHwEn = (on_timeslot_select == RRC_SLOT_HWEN1) ||
                          (on_timeslot_select == RRC_SLOT_HWEN2);
    wire logic hwEnLevel = ((on_timeslot_select == RRC_SLOT_HWEN1) && hwe1) ||
                           ((on_timeslot_select == RRC_SLOT_HWEN2) && hwe2);

    // ------------------------------------------------------------
    // Sequencer slot decode
    // ------------------------------------------------------------
    wire logic sleepDisables = (sleep_timeslot_select != RRC_SLOT_NEVER) &&
                               (sleep_timeslot_select <= RRC_SLOT_LAST);
    logic [2:0] sleepSlotNum;
    always_comb begin
        unique case (sleep_timeslot_select)
            RRC_SLOT_NEVER: sleepSlotNum = RRC_SLP_TS5;
            RRC_SLOT_HWEN1: sleepSlotNum = RRC_SLP_TS3;
            RRC_SLOT_HWEN2: sleepSlotNum = RRC_SLP_TS1;
            default: sleepSlotNum = RRC_SLP_SUM - sleep_timeslot_select;
        endcase
    end

    wire logic onSlotHit = startupSlotPulse && !onByHwEn &&
                           (on_timeslot_select != RRC_SLOT_NEVER) &&
                           (on_timeslot_select == startupSlot);
    wire logic sleepSlotHit = sleepSlotPulse && (sleepSlot == sleepSlotNum);

    // Hardware enabled rail: slot code picks when the sleep condition is taken
    wire logic hwEnSleepHit = sleepSlotPulse && onByHwEn && sleepDisables &&
                              (sleepSlot == sleepSlotNum);

    // ------------------------------------------------------------
    // Rail state machine
    // ------------------------------------------------------------
    wire logic uvAct = uvEvent && (undervoltage_action == RRC_ACT_RAIL_OFF);
    wire logic uvSys = uvEvent && (undervoltage_action == RRC_ACT_SYS_OFF);

    always_comb begin
        next_state = state;
        unique case (state)
            RRC_OFF: begin
                if (onSlotHit || (onByHwEn && hwEnLevel)) next_state = RRC_ON;
            end
            RRC_ON: begin
                if (uvAct) next_state = RRC_FAULT;
                else if (onByHwEn && !hwEnLevel) next_state = RRC_OFF;
                else if (hwEnSleepHit) next_state = RRC_SLEEP;
                else if (!onByHwEn && sleepSlotHit)
                    next_state = sleepDisables ? RRC_OFF : RRC_SLEEP;
            end
            RRC_SLEEP: begin
                if (uvAct) next_state = RRC_FAULT;
                else if (onByHwEn && !hwEnLevel) next_state = RRC_OFF;
                else if (wakeRequest) next_state = RRC_ON;
            end
            RRC_FAULT: begin
                if (wrOn || wrControl) next_state = RRC_OFF;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) state <= RRC_OFF;
        else        state <= next_state;
    end

    // ------------------------------------------------------------
    // Rail outputs
    // ------------------------------------------------------------
    rrc_rail_s rail;
    always_comb begin
        rail.enable     = (next_state == RRC_ON) || (next_state == RRC_SLEEP);
        rail.lowPower   = (next_state == RRC_SLEEP) ? sleep_power_mode
                                                    : on_power_mode;
        rail.voltCode   = (next_state == RRC_SLEEP) ? sleep_voltage_code
                                                    : on_voltage_code;
        rail.floatOff   = output_float_when_off;
        rail.switchMode = pass_switch_mode;
        if (hwcActive && rail.enable) begin
            rail.voltCode = hw_control_voltage_pick ? sleep_voltage_code
                                                    : on_voltage_code;
            if (hw_control_rail_mode == RRC_HMODE_OFF) rail.enable = 1'b0;
            else if (hw_control_rail_mode == RRC_HMODE_ONMODE)
                rail.lowPower = on_power_mode;
            else rail.lowPower = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            railEnable     <= 1'b0;
            railLowPower   <= 1'b0;
            railVoltCode   <= 5'h00;
            railFloatOff   <= 1'b0;
            railSwitchMode <= 1'b0;
            railDischarge  <= 1'b0;
            systemResetReq <= 1'b0;
        end else begin
            railEnable     <= rail.enable;
            railLowPower   <= rail.lowPower;
            railVoltCode   <= rail.voltCode;
            railFloatOff   <= rail.floatOff;
            railSwitchMode <= rail.switchMode;
            railDischarge  <= !rail.enable && !rail.floatOff;
            systemResetReq <= uvSys;
        end
    end

    // ------------------------------------------------------------
    // Read data, one cycle after the strobe
    // ------------------------------------------------------------
    logic [15:0] readMux;
    always_comb begin
        unique case (bus.addr)
            RRC_ADDR_CONTROL:   readMux = controlReg;
            RRC_ADDR_ON_CTRL:   readMux = onReg;
            RRC_ADDR_SLEEP:     readMux = sleepReg;
            RRC_ADDR_IRQ_STAT:  readMux = {15'h0000, irqStatus};
            RRC_ADDR_IRQ_MASK:  readMux = {15'h0000, irqMask};
            RRC_ADDR_RAIL_STAT: readMux = {12'h000, railLowPower, railEnable, 2'(state)};
            default:            readMux = 16'h0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)     regRdata <= 16'h0000;
        else if (bus.rd) regRdata <= readMux;
        else            regRdata <= 16'h0000;
    end

endmodule

// ---- verif/rrc_rail_regs_props.sv ----
// Port-level checker for the rail control bank
`timescale 1ns/100ps
module rrc_rail_regs_props
    import rrc_pkg::*;
#(
    parameter int SLOT_COUNT = 5
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic        regWr,
    input wire logic        regRd,
    input wire logic [15:0] regRdata,
    input wire logic        underVoltPin,
    input wire logic        railEnable,
    input wire logic        railFloatOff,
    input wire logic        railDischarge,
    input wire logic        systemResetReq,
    input wire logic        irq
);
    default clocking dc @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------
    sequence s_wr_rd(a);
        (regWr && regAddr == a) ##1 (regRd && regAddr == a);
    endsequence
    property p_rd_idle;
        !regRd |=> regRdata == 16'h0000;
    endproperty
    property p_unmapped;
        regRd && regAddr == 16'h4083 |=> regRdata == 16'h0000;
    endproperty
    property p_wr_rd_ctrl;
        s_wr_rd(RRC_ADDR_CONTROL) |=> regRdata == ($past(regWdata, 2) & 16'hDFC0);
    endproperty
    property p_wr_rd_on;
        s_wr_rd(RRC_ADDR_ON_CTRL) |=> regRdata == ($past(regWdata, 2) & 16'hE11F);
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    a_unmapped: assert property (p_unmapped) else $error("hole read not zero");
    a_wr_rd_ctrl: assert property (p_wr_rd_ctrl) else $error("control readback");
    a_wr_rd_on: assert property (p_wr_rd_on) else $error("on readback");

    // ------------------------------------------------------------
    // Rail and fault outputs
    // ------------------------------------------------------------
    property p_discharge;
        railDischarge |-> !railEnable && !railFloatOff;
    endproperty
    property p_sys_pulse;
        systemResetReq |=> !systemResetReq;
    endproperty
    property p_sys_cause;
        systemResetReq |-> $past(underVoltPin, 2) || $past(underVoltPin, 3)
            || $past(underVoltPin, 4) || $past(underVoltPin, 5);
    endproperty
    property p_irq_cause;
        $rose(irq) |-> $past(underVoltPin, 2) || $past(underVoltPin, 3)
            || $past(underVoltPin, 4) || $past(underVoltPin, 5)
            || $past(regWr) || $past(regWr, 2);
    endproperty
    a_discharge: assert property (p_discharge) else $error("discharge while on");
    a_sys_pulse: assert property (p_sys_pulse) else $error("reset pulse too long");
    a_sys_cause: assert property (p_sys_cause) else $error("reset without fault");
    a_irq_cause: assert property (p_irq_cause) else $error("irq without cause");
endmodule

bind rrc_rail_regs rrc_rail_regs_props #(.SLOT_COUNT(SLOT_COUNT)) rrc_rail_regs_props_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .underVoltPin(underVoltPin),
    .railEnable(railEnable), .railFloatOff(railFloatOff), .railDischarge(railDischarge),
    .systemResetReq(systemResetReq), .irq(irq)
);

// ---- verif/rrc_rail_regs_tb.sv ----
// Self-checking bench for the rail control bank
`timescale 1ns/100ps
module rrc_rail_regs_tb
    import rrc_pkg::*;
;
    logic        ref_clk, rst_n, regWr, regRd, startupSlotPulse, sleepSlotPulse;
    logic [15:0] regAddr, regWdata, regRdata, q;
    logic [2:0]  startupSlot, sleepSlot;
    logic        wakeRequest, hwControl1Pin, hwControl2Pin, hwEnable1Pin, hwEnable2Pin;
    logic        underVoltPin, railEnable, railLowPower, railFloatOff, railSwitchMode;
    logic        railDischarge, systemResetReq, irq;
    logic [4:0]  railVoltCode;
    int          err_count, compares, cycles, srCount;
    logic [15:0] addrTab [3] = '{RRC_ADDR_CONTROL, RRC_ADDR_ON_CTRL, RRC_ADDR_SLEEP};
    logic [15:0] rstTab  [3] = '{16'h0200, 16'h0000, 16'h0100};
    logic [15:0] maskTab [3] = '{16'hDFC0, 16'hE11F, 16'hE11F};
    logic [15:0] hwcCtrl [5] = '{16'h0C00, 16'h0C00, 16'h1700, 16'h1A00, 16'h1E00};
    logic [1:0]  hwcPins [5] = '{2'h1, 2'h2, 2'h2, 2'h1, 2'h2};
    logic [6:0]  hwcExp  [5] = '{7'h7F, 7'h4D, 7'h5F, 7'h6D, 7'h7F};

    rrc_rail_regs #(.SLOT_COUNT(5)) rrc_rail_regs_i (
        .ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .startupSlotPulse(startupSlotPulse), .startupSlot(startupSlot),
        .sleepSlotPulse(sleepSlotPulse), .sleepSlot(sleepSlot), .wakeRequest(wakeRequest),
        .hwControl1Pin(hwControl1Pin), .hwControl2Pin(hwControl2Pin),
        .hwEnable1Pin(hwEnable1Pin), .hwEnable2Pin(hwEnable2Pin),
        .underVoltPin(underVoltPin), .railEnable(railEnable), .railLowPower(railLowPower),
        .railVoltCode(railVoltCode), .railFloatOff(railFloatOff),
        .railSwitchMode(railSwitchMode), .railDischarge(railDischarge),
        .systemResetReq(systemResetReq), .irq(irq)
    );

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk) begin
        cycles++;
        if (systemResetReq === 1'b1) srCount++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    // ------------------------------------------------------------
    // Access tasks: wr, rdc, wr_rd, spulse and tick start on a rising edge and end settled; chk and rail compare at once
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge ref_clk);
        regWr <= 1'b0;
        #1;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        chk(regRdata, e);
    endtask
    task automatic wr_rd(input logic [15:0] a, input logic [15:0] d);
        wr(a, d);
        regRd <= 1'b1;
        @(posedge ref_clk);
        regRd <= 1'b0;
        #1;
        q = regRdata;
    endtask
    task automatic spulse(input logic sl, input logic [2:0] n);
        @(posedge ref_clk);
        sleepSlotPulse <= sl;
        startupSlotPulse <= !sl;
        sleepSlot <= n;
        startupSlot <= n;
        @(posedge ref_clk);
        sleepSlotPulse <= 1'b0;
        startupSlotPulse <= 1'b0;
        #1;
    endtask
    task automatic rail(input logic [6:0] e);
        chk({9'h0, railEnable, railLowPower, railVoltCode}, {9'h0, e});
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        rst_n = 1'b0;
        {regAddr, regWdata, regWr, regRd, startupSlotPulse, startupSlot} = '0;
        {sleepSlotPulse, sleepSlot, wakeRequest, hwControl1Pin, hwControl2Pin} = '0;
        {hwEnable1Pin, hwEnable2Pin, underVoltPin} = '0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) rdc(addrTab[i], rstTab[i]);
        rdc(RRC_ADDR_IRQ_MASK, 16'h0001);
        rdc(16'h4083, 16'h0000);
        for (int i = 0; i < 3; i++) begin
            wr_rd(addrTab[i], 16'hFFFF);
            chk(q, maskTab[i]);
        end
        chk({14'h0, railFloatOff, railSwitchMode}, 16'h0003);
        for (int i = 0; i < 3; i++) wr(addrTab[i], rstTab[i]);
        wr(RRC_ADDR_ON_CTRL, 16'h400D);
        tick(2);
        chk({15'h0, railDischarge}, 16'h0001);
        spulse(1'b0, 3'h1);
        chk({15'h0, railEnable}, 16'h0000);
        spulse(1'b0, 3'h2);
        rail(7'h4D);
        rdc(RRC_ADDR_RAIL_STAT, 16'h0005);
        wr(RRC_ADDR_SLEEP, 16'hC11F);
        spulse(1'b1, 3'h5);
        rail(7'h4D);
        spulse(1'b1, 3'h3);
        rail(7'h7F);
        rdc(RRC_ADDR_RAIL_STAT, 16'h000E);
        wakeRequest <= 1'b1;
        tick(1);
        wakeRequest <= 1'b0;
        tick(2);
        rail(7'h4D);
        for (int i = 0; i < 5; i++) begin
            wr(RRC_ADDR_CONTROL, hwcCtrl[i]);
            {hwControl2Pin, hwControl1Pin} <= hwcPins[i];
            tick(5);
            rail(hwcExp[i]);
            {hwControl2Pin, hwControl1Pin} <= 2'h0;
            tick(5);
        end
        wr(RRC_ADDR_CONTROL, 16'h0200);
        wr(RRC_ADDR_SLEEP, 16'h4100);
        spulse(1'b1, 3'h5);
        rail(7'h4D);
        spulse(1'b1, 3'h4);
        chk({14'h0, railEnable, railDischarge}, 16'h0001);
        wr(RRC_ADDR_CONTROL, 16'h0280);
        tick(2);
        chk({14'h0, railFloatOff, railDischarge}, 16'h0002);
        wr(RRC_ADDR_CONTROL, 16'h4200);
        spulse(1'b0, 3'h2);
        rail(7'h4D);
        underVoltPin <= 1'b1;
        tick(6);
        chk({14'h0, railEnable, irq}, 16'h0001);
        underVoltPin <= 1'b0;
        wr(RRC_ADDR_IRQ_STAT, 16'h0001);
        tick(3);
        chk({15'h0, irq}, 16'h0000);
        wr(RRC_ADDR_IRQ_MASK, 16'h0000);
        wr(RRC_ADDR_CONTROL, 16'h0200);
        underVoltPin <= 1'b1;
        tick(6);
        underVoltPin <= 1'b0;
        chk({15'h0, irq}, 16'h0000);
        rdc(RRC_ADDR_IRQ_STAT, 16'h0001);
        wr(RRC_ADDR_IRQ_MASK, 16'h0001);
        tick(3);
        chk({15'h0, irq}, 16'h0001);
        wr(RRC_ADDR_IRQ_STAT, 16'h0001);
        wr(RRC_ADDR_CONTROL, 16'h8200);
        underVoltPin <= 1'b1;
        tick(10);
        underVoltPin <= 1'b0;
        chk(srCount[15:0], 16'h0001);
        wr(RRC_ADDR_CONTROL, 16'h0200);
        spulse(1'b0, 3'h2);
        wr(RRC_ADDR_CONTROL, 16'h0900);
        hwControl1Pin <= 1'b1;
        tick(5);
        chk({15'h0, railEnable}, 16'h0000);
        hwControl1Pin <= 1'b0;
        wr(RRC_ADDR_CONTROL, 16'h0200);
        wr(RRC_ADDR_ON_CTRL, 16'hE00D);
        tick(5);
        chk({15'h0, railEnable}, 16'h0000);
        hwEnable2Pin <= 1'b1;
        tick(5);
        chk({15'h0, railEnable}, 16'h0001);
        spulse(1'b1, 3'h2);
        rail(7'h4D);
        spulse(1'b1, 3'h4);
        rail(7'h60);
        rdc(RRC_ADDR_RAIL_STAT, 16'h000E);
        close_out();
    end
endmodule
